// *** core/wrt_watchdog.sv ***
// wrt_watchdog: watchdog down-counter, refresh, time-out response and reset-cause flags
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operation
// - first enable loads the counter with the 24-bit reload value
// - counter decrements to zero; zero means time-out unless refreshed first
// - refresh instruction reloads the counter, then counting resumes
// - debug mode refreshes continuously so no time-out occurs
// - time-out gives interrupt or system reset, chosen by the option bit
// - option bit 1 selects reset, 0 selects interrupt
// - reset time-out sets the time-out flag in the reset-cause register
// - interrupt time-out raises the request and sets the time-out flag
// - after interrupt time-out the counter wraps to 0x0fffff, no reload
// - reading reset-cause clears the time-out flag, stopping repeat interrupts
// - interrupt time-out in stop mode starts stop recovery and interrupts
// - interrupt time-out in stop mode sets both time-out and stop-recovery flags
// - pending interrupt stays until taken after stop recovery completes
// - control register is write-only; two-byte sequence unlocks reload bytes
// - unlock writes change nothing stored; address shared with reset-cause
// - upper, high and low reload bytes form the 24-bit reload value
// - reload byte writes set reload; reads return the live count
// ------------------------------------------------------------
module wrt_watchdog
  import wrt_pkg::*;
#(
  parameter int TICK_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WRT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refresh_instr,
  input wire logic stop_mode,
  input wire logic ext_reset_event,
  input wire logic irq_clear,
  input wire logic debug_mode_pin,
  input wire logic timeout_response_select,
  input wire logic lvd_level,
  output logic wdt_irq,
  output logic sys_reset_req,
  output logic stop_recovery_req
);
  localparam int DW = $clog2(TICK_DIV) + 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

  // ------------------------------------------------------------
  // pin inputs
  // ------------------------------------------------------------
  logic [WRT_SYNC_W-1:0] pins_s;
  logic dbg_s;
  logic resp_s;
  logic lvd_s;

  wrt_sync #(
    .W(WRT_SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({lvd_level, timeout_response_select, debug_mode_pin}),
    .dout(pins_s)
  );

  assign dbg_s = pins_s[0];
  assign resp_s = pins_s[1];
  assign lvd_s = pins_s[2];

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [WRT_AW-1:0] a, input logic [WRT_AW-1:0] r);
    return a == r;
  endfunction

  logic setup_rd;
  logic acc;
  logic mapped;
  logic ctl_wr;
  logic ctl_rd;
  logic cfg_wr;
  logic rl_wr;
  logic unlocked;

  assign acc = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign mapped = hit(paddr, WRT_CTL_ADDR) | hit(paddr, WRT_RLU_ADDR)
                | hit(paddr, WRT_RLH_ADDR) | hit(paddr, WRT_RLL_ADDR)
                | hit(paddr, WRT_CFG_ADDR);
  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  // shared address: write goes to the unlock sequence, read to reset-cause
  assign ctl_wr = acc & pwrite & hit(paddr, WRT_CTL_ADDR);
  assign ctl_rd = acc & ~pwrite & hit(paddr, WRT_CTL_ADDR);
  assign cfg_wr = acc & pwrite & hit(paddr, WRT_CFG_ADDR);
  assign rl_wr = acc & pwrite & unlocked & (hit(paddr, WRT_RLU_ADDR)
               | hit(paddr, WRT_RLH_ADDR) | hit(paddr, WRT_RLL_ADDR));

  wrt_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .ctl_wr(ctl_wr),
    .relock(rl_wr & hit(paddr, WRT_RLL_ADDR)),
    .wdata(pwdata[7:0]),
    .unlocked(unlocked)
  );

  // ------------------------------------------------------------
  // reload value and enable
  // ------------------------------------------------------------
  logic [23:0] reload_q;
  logic en_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= WRT_RELOAD_RST;
    end else if (rl_wr) begin
      if (hit(paddr, WRT_RLU_ADDR)) begin
        reload_q[23:16] <= pwdata[7:0];
      end
      if (hit(paddr, WRT_RLH_ADDR)) begin
        reload_q[15:8] <= pwdata[7:0];
      end
      if (hit(paddr, WRT_RLL_ADDR)) begin
        reload_q[7:0] <= pwdata[7:0];
      end
    end
  end

  // sticky: a watchdog that software could switch off would guard nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (cfg_wr & pwdata[WRT_CFG_EN]) begin
      en_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // count tick divider
  // ------------------------------------------------------------
  logic [DW-1:0] div_q;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (!en_q || div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = en_q & (div_q == DIV_LAST);

  // ------------------------------------------------------------
  // down-counter and time-out
  // ------------------------------------------------------------
  logic [23:0] count_q;
  logic first_en;
  logic timeout;
  logic rst_to;
  logic irq_to;
  logic stop_to;
  logic load_now;

  assign first_en = cfg_wr & pwdata[WRT_CFG_EN] & ~en_q;
  assign timeout = tick & (count_q == WRT_ZERO) & ~refresh_instr & ~dbg_s;
  assign rst_to = timeout & resp_s;
  assign irq_to = timeout & ~resp_s;
  assign stop_to = irq_to & stop_mode;
  assign load_now = first_en | refresh_instr | dbg_s | rst_to;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= WRT_RELOAD_RST;
    end else if (load_now) begin
      count_q <= reload_q;
    end else if (irq_to) begin
      count_q <= WRT_WRAP;
    end else if (tick && count_q != WRT_ZERO) begin
      count_q <= count_q - WRT_STEP;
    end
  end

  // ------------------------------------------------------------
  // time-out responses
  // ------------------------------------------------------------
  logic wdt_flag_q;
  logic stop_flag_q;
  logic por_flag_q;
  logic ext_flag_q;
  logic [31:0] rdata_q;
  logic clr_wdt;
  logic clr_stop;
  logic clr_por;
  logic clr_ext;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req <= 1'b0;
      stop_recovery_req <= 1'b0;
    end else begin
      sys_reset_req <= rst_to;
      stop_recovery_req <= stop_to;
    end
  end

  // clearing re-raises while the flag still stands and the interrupt response is selected; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq <= 1'b0;
    end else if (irq_to) begin
      wdt_irq <= 1'b1;
    end else if (irq_clear) begin
      wdt_irq <= wdt_flag_q & ~clr_wdt & ~resp_s;
    end
  end

  // ------------------------------------------------------------
  // reset-cause flags
  // ------------------------------------------------------------
  // only bits actually returned by the read are cleared, so an event
  // landing between setup and access is never lost
  assign clr_wdt = ctl_rd & rdata_q[WRT_WDT_BIT];
  assign clr_stop = ctl_rd & rdata_q[WRT_STOP_BIT];
  assign clr_por = ctl_rd & rdata_q[WRT_POR_BIT];
  assign clr_ext = ctl_rd & rdata_q[WRT_EXT_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_flag_q <= 1'b0;
    end else if (timeout) begin
      wdt_flag_q <= 1'b1;
    end else if (clr_wdt) begin
      wdt_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_flag_q <= 1'b0;
    end else if (stop_to) begin
      stop_flag_q <= 1'b1;
    end else if (timeout || clr_stop) begin
      stop_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_flag_q <= 1'b1;
    end else if (timeout || clr_por) begin
      por_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_flag_q <= 1'b0;
    end else if (ext_reset_event) begin
      ext_flag_q <= 1'b1;
    end else if (clr_ext) begin
      ext_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (setup_rd) begin
      rdata_q <= '0;
      if (hit(paddr, WRT_CTL_ADDR)) begin
        rdata_q[WRT_POR_BIT] <= por_flag_q;
        rdata_q[WRT_STOP_BIT] <= stop_flag_q;
        rdata_q[WRT_WDT_BIT] <= wdt_flag_q;
        rdata_q[WRT_EXT_BIT] <= ext_flag_q;
        rdata_q[WRT_LVD_BIT] <= lvd_s;
      end
      if (hit(paddr, WRT_RLU_ADDR)) begin
        rdata_q[7:0] <= count_q[23:16];
      end
      if (hit(paddr, WRT_RLH_ADDR)) begin
        rdata_q[7:0] <= count_q[15:8];
      end
      if (hit(paddr, WRT_RLL_ADDR)) begin
        rdata_q[7:0] <= count_q[7:0];
      end
      if (hit(paddr, WRT_CFG_ADDR)) begin
        rdata_q[WRT_CFG_EN] <= en_q;
        rdata_q[WRT_CFG_IRQ] <= wdt_irq;
        rdata_q[WRT_CFG_UNLK] <= unlocked;
      end
    end
  end

  // control register holds nothing, so no read path exists for it
  assign prdata = rdata_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  first_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_en |=> count_q == $past(reload_q))
    else $error("first enable did not load the reload value");

  count_step_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick && !load_now && count_q != WRT_ZERO |=> count_q == $past(count_q) - WRT_STEP)
    else $error("counter did not step down by one");

  refresh_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    refresh_instr && reload_q > WRT_STEP |=> count_q == $past(reload_q) ##1 !timeout)
    else $error("refresh did not reload the counter");

  debug_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    dbg_s |-> !timeout ##1 (count_q == $past(reload_q)))
    else $error("time-out or no reload during debug");

  reset_resp_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout && resp_s |=> sys_reset_req && wdt_flag_q ##1 !sys_reset_req)
    else $error("reset response wrong");

  irq_resp_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout && !resp_s |=> wdt_irq && wdt_flag_q && count_q == WRT_WRAP && !sys_reset_req)
    else $error("interrupt response wrong");

  read_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_wdt && !timeout |=> !wdt_flag_q)
    else $error("reset-cause read did not clear the flag");

  stop_wake_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    stop_to |=> stop_recovery_req && stop_flag_q && wdt_flag_q && wdt_irq)
    else $error("stop-mode time-out response wrong");

  irq_pending_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdt_irq && !irq_clear |=> wdt_irq)
    else $error("pending interrupt dropped");

  locked_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc && pwrite && !unlocked && !hit(paddr, WRT_CTL_ADDR) |=> $stable(reload_q))
    else $error("locked reload write took effect");

  count_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_rd && hit(paddr, WRT_RLL_ADDR) |=> prdata[7:0] == $past(count_q[7:0]))
    else $error("reload read did not return the count");

  irq_timeout_c: cover property (@(posedge pclk) disable iff (!presetn) irq_to);
  rst_timeout_c: cover property (@(posedge pclk) disable iff (!presetn) rst_to);
  stop_wake_c: cover property (@(posedge pclk) disable iff (!presetn) stop_to);
  unlock_c: cover property (@(posedge pclk) disable iff (!presetn) rl_wr);
endmodule

// *** core/wrt_pkg.sv ***
// wrt_pkg: shared constants and types of the watchdog refresh block
package wrt_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam int WRT_AW = 12;
  localparam logic [11:0] WRT_CTL_ADDR = 12'hff0;
  localparam logic [11:0] WRT_RLU_ADDR = 12'hff4;
  localparam logic [11:0] WRT_RLH_ADDR = 12'hff8;
  localparam logic [11:0] WRT_RLL_ADDR = 12'hffc;
  localparam logic [11:0] WRT_CFG_ADDR = 12'hfe8;
  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [7:0] WRT_UNLOCK_1 = 8'h55;
  localparam logic [7:0] WRT_UNLOCK_2 = 8'haa;
  localparam logic [23:0] WRT_ZERO = 24'h000000;
  localparam logic [23:0] WRT_WRAP = 24'h0fffff;
  localparam logic [23:0] WRT_STEP = 24'h000001;
  localparam logic [23:0] WRT_RELOAD_RST = 24'h000400;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int WRT_POR_BIT = 7;
  localparam int WRT_STOP_BIT = 6;
  localparam int WRT_WDT_BIT = 5;
  localparam int WRT_EXT_BIT = 4;
  localparam int WRT_LVD_BIT = 0;
  localparam int WRT_CFG_EN = 0;
  localparam int WRT_CFG_IRQ = 1;
  localparam int WRT_CFG_UNLK = 2;
  localparam int WRT_SYNC_W = 3;
  // ------------------------------------------------------------
  // unlock sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    WRT_LOCKED = 3'b001,
    WRT_HALF = 3'b010,
    WRT_OPEN = 3'b100
  } wrt_lock_t;
endpackage

// *** core/wrt_sync.sv ***
// wrt_sync: two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module wrt_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// *** core/wrt_unlock.sv ***
// wrt_unlock: two-byte unlock sequence guarding the reload bytes
`timescale 1ns/1ps
module wrt_unlock
  import wrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ctl_wr,
  input wire logic relock,
  input wire logic [7:0] wdata,
  output logic unlocked
);
  wrt_lock_t state_q;

  // nothing of the written byte is stored; only the sequence moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= WRT_LOCKED;
    end else if (ctl_wr) begin
      unique case (state_q)
        WRT_LOCKED: state_q <= (wdata == WRT_UNLOCK_1) ? WRT_HALF : WRT_LOCKED;
        WRT_HALF: state_q <= (wdata == WRT_UNLOCK_2) ? WRT_OPEN : WRT_LOCKED;
        WRT_OPEN: state_q <= (wdata == WRT_UNLOCK_1) ? WRT_HALF : WRT_LOCKED;
        default: state_q <= WRT_LOCKED;
      endcase
    end else if (relock) begin
      state_q <= WRT_LOCKED;
    end
  end

  assign unlocked = (state_q == WRT_OPEN);

  seq_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_wr && (state_q == WRT_HALF) && (wdata != WRT_UNLOCK_2) |=> state_q == WRT_LOCKED)
    else $error("unlock sequence did not restart");
endmodule

// *** testbench/wrt_core_model.sv ***
// wrt_core_model: interrupt controller and reset logic beside the watchdog
`timescale 1ns/1ps
module wrt_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wdt_irq,
  input wire logic sys_reset_req,
  input wire logic stop_recovery_req,
  input wire logic ack_go,
  input wire logic [3:0] ack_wait,
  output logic irq_clear,
  output int n_rst,
  output int n_rec
);
  logic [3:0] wait_q;
  logic busy_q;
  // ------------------------------------------------------------
  // acknowledge, optionally slow, only for a raised request
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      irq_clear <= 1'b0;
    end else begin
      irq_clear <= 1'b0;
      if (ack_go && !busy_q && wdt_irq) begin
        busy_q <= 1'b1;
        wait_q <= ack_wait;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        irq_clear <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // pulse counters
  // ------------------------------------------------------------
  // a real reset would restart the core; here it is only counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_rst <= 0;
      n_rec <= 0;
    end else begin
      n_rst <= n_rst + int'(sys_reset_req);
      n_rec <= n_rec + int'(stop_recovery_req);
    end
  end
endmodule

// *** testbench/testbench.sv ***
// testbench: random and corner-case checks of the watchdog block
`timescale 1ns/1ps
module testbench;
  import wrt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [WRT_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic refresh_instr = 1'b0;
  logic stop_mode = 1'b0;
  logic ext_reset_event = 1'b0;
  logic debug_mode_pin = 1'b0;
  logic timeout_response_select = 1'b1;
  logic lvd_level;
  logic irq_clear;
  logic wdt_irq;
  logic sys_reset_req;
  logic stop_recovery_req;
  logic ack_go = 1'b0;
  logic [3:0] ack_wait;
  logic [31:0] q;
  logic e;
  logic [7:0] r;
  int n_rst;
  int n_rec;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;
  int base;
  always #5 pclk = ~pclk;
  wrt_watchdog #(.TICK_DIV(1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refresh_instr(refresh_instr),
    .stop_mode(stop_mode), .ext_reset_event(ext_reset_event), .irq_clear(irq_clear),
    .debug_mode_pin(debug_mode_pin), .timeout_response_select(timeout_response_select),
    .lvd_level(lvd_level), .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req),
    .stop_recovery_req(stop_recovery_req));
  wrt_core_model core (.pclk(pclk), .presetn(presetn), .wdt_irq(wdt_irq),
    .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req),
    .ack_go(ack_go), .ack_wait(ack_wait), .irq_clear(irq_clear), .n_rst(n_rst),
    .n_rec(n_rec));
  // ------------------------------------------------------------
  // expectations, compare and close
  // ------------------------------------------------------------
  function automatic logic [31:0] cause(input logic por, stop, tmo, ext, lvd);
    return {24'h0, por, stop, tmo, ext, 3'b000, lvd};
  endfunction
  function automatic logic [31:0] win(input int v, lo, hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task automatic test_done();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // bus and wait helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic pulse_refresh();
    refresh_instr <= 1'b1;
    tick(1);
    refresh_instr <= 1'b0;
  endtask
  task automatic ack();
    ack_go <= 1'b1;
    tick(1);
    ack_go <= 1'b0;
    tick(int'(ack_wait) + 4);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h213a));
    lvd_level <= 1'($urandom_range(0, 1));
    r = 8'($urandom_range(24, 60));
    ack_wait <= 4'($urandom_range(0, 9));
    tick(2);
    presetn <= 1'b1;
    tick(3);
    rd_chk(WRT_CTL_ADDR, cause(1, 0, 0, 0, lvd_level));
    rd_chk(WRT_CTL_ADDR, cause(0, 0, 0, 0, lvd_level));
    rd_chk(WRT_CFG_ADDR, 32'h0);
    rd_chk(WRT_RLH_ADDR, 32'h04);
    rd_chk(WRT_RLL_ADDR, 32'h00);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1);
    ext_reset_event <= 1'b1;
    tick(1);
    ext_reset_event <= 1'b0;
    rd_chk(WRT_CTL_ADDR, cause(0, 0, 0, 1, lvd_level));
    // locked write must not change the reload
    apb(1'b1, WRT_RLL_ADDR, 32'h11);
    apb(1'b1, WRT_CTL_ADDR, 32'h55);
    apb(1'b1, WRT_CTL_ADDR, 32'h12);
    apb(1'b1, WRT_CTL_ADDR, 32'haa);
    rd_chk(WRT_CFG_ADDR, 32'h0);
    apb(1'b1, WRT_CTL_ADDR, 32'h55);
    apb(1'b1, WRT_CTL_ADDR, 32'haa);
    rd_chk(WRT_CFG_ADDR, 32'h4);
    rd_chk(WRT_CTL_ADDR, cause(0, 0, 0, 0, lvd_level));
    apb(1'b1, WRT_RLU_ADDR, 32'h0);
    apb(1'b1, WRT_RLH_ADDR, 32'h0);
    apb(1'b1, WRT_RLL_ADDR, {24'h0, r});
    apb(1'b1, WRT_CFG_ADDR, 32'h1);
    base = n_rst;
    for (k = 0; n_rst == base && k < 300; k++) tick(1);
    chk(win(k, r, r + 6), 32'h1);
    rd_chk(WRT_CTL_ADDR, cause(0, 0, 1, 0, lvd_level));
    chk({31'h0, wdt_irq}, 32'h0);
    debug_mode_pin <= 1'b1;
    tick(4);
    base = n_rst;
    tick(3 * r);
    chk(32'(n_rst - base), 32'h0);
    debug_mode_pin <= 1'b0;
    repeat (6) begin
      tick(r / 2);
      pulse_refresh();
    end
    chk(32'(n_rst - base), 32'h0);
    for (k = 0; n_rst == base && k < 300; k++) tick(1);
    chk(win(k, r, r + 6), 32'h1);
    // ------------------------------------------------------------
    // interrupt response
    // ------------------------------------------------------------
    debug_mode_pin <= 1'b1;
    timeout_response_select <= 1'b0;
    tick(4);
    apb(1'b0, WRT_CTL_ADDR, 32'h0);
    base = n_rst;
    debug_mode_pin <= 1'b0;
    for (k = 0; wdt_irq !== 1'b1 && k < 300; k++) tick(1);
    chk(win(k, r, r + 8), 32'h1);
    chk(32'(n_rst - base), 32'h0);
    rd_chk(WRT_RLU_ADDR, 32'h0f);
    ack();
    chk({31'h0, wdt_irq}, 32'h1);
    rd_chk(WRT_CTL_ADDR, cause(0, 0, 1, 0, lvd_level));
    ack();
    chk({31'h0, wdt_irq}, 32'h0);
    // ------------------------------------------------------------
    // time-out in stop mode
    // ------------------------------------------------------------
    pulse_refresh();
    stop_mode <= 1'b1;
    base = n_rec;
    for (k = 0; n_rec == base && k < 300; k++) tick(1);
    chk(win(k, r, r + 6), 32'h1);
    chk({31'h0, wdt_irq}, 32'h1);
    stop_mode <= 1'b0;
    rd_chk(WRT_CTL_ADDR, cause(0, 1, 1, 0, lvd_level));
    ack();
    test_done();
  end
endmodule
